/* src/crba_consts.svh */
`ifndef CRBA_CONSTS_SVH
`define CRBA_CONSTS_SVH
// Summary of operation
// - one 64 KB space for all areas
// - 16-bit program counter locates fetched instruction
// - 16-bit accumulator; byte ops use low byte
// - 16-bit temporary accumulator, second operand, low byte
// - 16-bit index, extra pointer, stack pointer
// - 16-bit status holds bank pointers and flags
// - upper byte pointers, lower byte condition codes
// - direct bank pointer remaps 0080h-00FFh windows
// - direct 0000h-007Fh never remapped
// - direct bank pointer zero leaves window unmapped
// - half carry from bit 3 to bit 4
// - interrupt enable flag, cleared at reset
// - accept only strictly higher priority level
// - 32 banks of eight 8-bit registers in memory
// - bank pointer selects active bank by fixed conversion
// - opcode low three bits pick register

// address widths
`define CRBA_ADDR_W        16
`define CRBA_DIR_WIN_BITS  7

// bus offsets, byte addresses
`define CRBA_OFF_PC        12'h000
`define CRBA_OFF_ACC       12'h004
`define CRBA_OFF_TMP       12'h008
`define CRBA_OFF_IDX       12'h00C
`define CRBA_OFF_EXT       12'h010
`define CRBA_OFF_STK       12'h014
`define CRBA_OFF_STAT      12'h018
`define CRBA_GP_WIN_SEL    2'h1

// program status field positions
`define CRBA_SR_RBP_MSB    15
`define CRBA_SR_RBP_LSB    11
`define CRBA_SR_DBP_MSB    10
`define CRBA_SR_DBP_LSB    8
`define CRBA_SR_H          7
`define CRBA_SR_I          6
`define CRBA_SR_LVL_HI     5
`define CRBA_SR_LVL_LO     4
`define CRBA_SR_N          3
`define CRBA_SR_Z          2
`define CRBA_SR_V          1
`define CRBA_SR_C          0

// reset values and memory bases
`define CRBA_SR_RESET      16'h0030
`define CRBA_REG_RESET     16'h0000
`define CRBA_DIR_MAP_BASE  16'h0100
`define CRBA_GP_BASE       16'h0100
`endif

/* src/crba_pkg.sv */
package crba_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_MEM  = 3'h2,
        ST_RESP = 3'h4
    } crba_bus_state_t;

    typedef enum logic [2:0] {
        ALU_ADD  = 3'h0,
        ALU_ADDC = 3'h1,
        ALU_SUB  = 3'h2,
        ALU_SUBC = 3'h3,
        ALU_MOVE = 3'h4
    } crba_alu_op_t;

    typedef enum logic [2:0] {
        LD_PC  = 3'h0,
        LD_ACC = 3'h1,
        LD_TMP = 3'h2,
        LD_IDX = 3'h3,
        LD_EXT = 3'h4,
        LD_STK = 3'h5,
        LD_STAT = 3'h6
    } crba_load_sel_t;
endpackage

/* src/crba_mem_if.sv */
`timescale 1ns/1ps
interface crba_mem_if #(
    parameter int AW = 8,
    parameter int DW = 8
);
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface

/* src/crba_gpmem.sv */
`timescale 1ns/1ps
module crba_gpmem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    crba_mem_if.mem  port
);
    logic [DW-1:0] mem_array [0:(1<<AW)-1];
    logic [DW-1:0] rdata_reg;

    // storage array, no reset: contents are undefined until written
    always_ff @(posedge hclk) begin
        if (ce && port.en && port.we) begin
            mem_array[port.addr] <= port.wdata;
        end
    end

    // registered read, write-first so a write returns its own data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= '0;
        end else if (ce && port.en) begin
            rdata_reg <= port.we ? port.wdata : mem_array[port.addr];
        end
    end

    assign port.rdata = rdata_reg;
endmodule // crba_gpmem

/* src/crba_regbank.sv */
`timescale 1ns/1ps
`include "crba_consts.svh"
module crba_regbank #(
    parameter int GP_BANKS = 32,
    parameter int GP_REGS  = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        pc_inc,
    input  wire logic        load_valid,
    input  wire logic [2:0]  load_sel,
    input  wire logic [15:0] load_data,
    input  wire logic        alu_valid,
    input  wire logic [2:0]  alu_op,
    input  wire logic        alu_wide,
    input  wire logic        dir_valid,
    input  wire logic [7:0]  dir_addr,
    output logic [15:0]      dir_mapped,
    output logic             dir_done,
    input  wire logic        gp_valid,
    input  wire logic        gp_write,
    input  wire logic [7:0]  gp_opcode,
    input  wire logic [7:0]  gp_wdata,
    output logic [15:0]      gp_addr,
    output logic [7:0]       gp_rdata,
    output logic             gp_ack,
    input  wire logic        irq_valid,
    input  wire logic [1:0]  irq_level,
    output logic             irq_accept,
    output logic [15:0]      program_counter,
    output logic [15:0]      accumulator,
    output logic [15:0]      temp_accumulator,
    output logic [15:0]      index_register,
    output logic [15:0]      extra_pointer,
    output logic [15:0]      stack_pointer,
    output logic [15:0]      program_status
);
    localparam int GP_AW = $clog2(GP_BANKS * GP_REGS);

    logic [15:0]               pc_reg, acc_reg, tmp_reg, idx_reg, ext_reg, stk_reg, status_reg;
    logic [15:0]               dir_mapped_reg, gp_addr_reg;
    logic                      dir_done_reg, gp_ack_reg, gp_pend_reg, irq_accept_reg;
    logic [7:0]                gp_rdata_reg;
    crba_pkg::crba_bus_state_t state_reg;
    logic                      hreadyout_reg, dph_wr_reg, ahb_gp_we_reg;
    logic [11:0]               dph_addr_reg;
    logic [31:0]               hrdata_reg;
    logic [GP_AW-1:0]          ahb_gp_idx_reg;
    logic                      accept, addr_low, in_gp_win, sw_wr;
    logic [31:0]               rd_mux;
    logic [4:0]                bank_ptr;
    logic [2:0]                dir_ptr, dir_ptr_m1;
    logic [1:0]                int_level;
    logic [15:0]               opa, opb, alu_res, acc_alu_next;
    logic [16:0]               sum17;
    logic                      cin, f_c, f_h, f_n, f_z, f_v, a_msb, b_msb, r_msb, is_sub;

    crba_mem_if #(.AW(GP_AW), .DW(8)) gp_bus ();

    crba_gpmem #(.AW(GP_AW), .DW(8)) u_gpmem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .port    (gp_bus.mem)
    );

    // status fields: bank pointers above, condition codes below
    assign bank_ptr   = status_reg[`CRBA_SR_RBP_MSB:`CRBA_SR_RBP_LSB];
    assign dir_ptr    = status_reg[`CRBA_SR_DBP_MSB:`CRBA_SR_DBP_LSB];
    assign dir_ptr_m1 = dir_ptr - 3'h1;
    assign int_level  = {status_reg[`CRBA_SR_LVL_HI], status_reg[`CRBA_SR_LVL_LO]};

    // bus request decode; upper address bits must be zero to hit
    assign accept    = hsel && htrans[1] && hready;
    assign addr_low  = (haddr[31:12] == 20'h00000);
    assign in_gp_win = addr_low && (haddr[11:10] == `CRBA_GP_WIN_SEL);
    assign sw_wr     = ce && dph_wr_reg;

    // register read mux, sampled in the address phase
    always_comb begin
        rd_mux = 32'h00000000;
        if (addr_low) begin
            case (haddr[11:0])
                `CRBA_OFF_PC:  rd_mux = {16'h0000, pc_reg};
                `CRBA_OFF_ACC: rd_mux = {16'h0000, acc_reg};
                `CRBA_OFF_TMP: rd_mux = {16'h0000, tmp_reg};
                `CRBA_OFF_IDX: rd_mux = {16'h0000, idx_reg};
                `CRBA_OFF_EXT: rd_mux = {16'h0000, ext_reg};
                `CRBA_OFF_STK: rd_mux = {16'h0000, stk_reg};
                `CRBA_OFF_STAT: rd_mux = {16'h0000, status_reg};
                default:       rd_mux = 32'h00000000;
            endcase
        end
    end

    // bus slave sequencer; register hits finish with no wait state,
    // gp window hits wait for the memory, which the core may hold off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg      <= crba_pkg::ST_IDLE;
            hreadyout_reg  <= 1'b1;
            hrdata_reg     <= 32'h00000000;
            dph_wr_reg     <= 1'b0;
            dph_addr_reg   <= 12'h000;
            ahb_gp_we_reg  <= 1'b0;
            ahb_gp_idx_reg <= '0;
        end else if (ce) begin
            case (state_reg)
                crba_pkg::ST_IDLE: begin
                    dph_wr_reg <= 1'b0;
                    if (accept && in_gp_win) begin
                        state_reg      <= crba_pkg::ST_MEM;
                        hreadyout_reg  <= 1'b0;
                        ahb_gp_we_reg  <= hwrite;
                        ahb_gp_idx_reg <= haddr[GP_AW+1:2];
                    end else if (accept) begin
                        hrdata_reg  <= hwrite ? 32'h00000000 : rd_mux;
                        dph_wr_reg   <= hwrite && addr_low;
                        dph_addr_reg <= haddr[11:0];
                    end
                end
                crba_pkg::ST_MEM: begin
                    if (!gp_valid) begin
                        state_reg <= crba_pkg::ST_RESP; // core port has priority
                    end
                end
                crba_pkg::ST_RESP: begin
                    hrdata_reg    <= ahb_gp_we_reg ? 32'h00000000 : {24'h000000, gp_bus.rdata};
                    hreadyout_reg <= 1'b1;
                    state_reg     <= crba_pkg::ST_IDLE;
                end
                default: begin
                    state_reg     <= crba_pkg::ST_IDLE;
                    hreadyout_reg <= 1'b1;
                end
            endcase
        end
    end

    // memory port: core request wins, bus access retries next cycle
    always_comb begin
        gp_bus.en    = gp_valid || (state_reg == crba_pkg::ST_MEM);
        gp_bus.we    = gp_valid ? gp_write : ahb_gp_we_reg;
        gp_bus.addr  = gp_valid ? {bank_ptr, gp_opcode[2:0]} : ahb_gp_idx_reg;
        gp_bus.wdata = gp_valid ? gp_wdata : hwdata[7:0];
    end

    // alu: operands narrowed to their low byte for byte operations
    always_comb begin
        is_sub = (alu_op == crba_pkg::ALU_SUB) || (alu_op == crba_pkg::ALU_SUBC);
        cin    = status_reg[`CRBA_SR_C] &&
                 ((alu_op == crba_pkg::ALU_ADDC) || (alu_op == crba_pkg::ALU_SUBC));
        opa    = alu_wide ? acc_reg : {8'h00, acc_reg[7:0]};
        opb    = alu_wide ? tmp_reg : {8'h00, tmp_reg[7:0]};
        if (is_sub) begin
            sum17 = {1'b0, opa} - {1'b0, opb} - {16'h0000, cin};
        end else begin
            sum17 = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
        end
        alu_res = (alu_op == crba_pkg::ALU_MOVE) ? opb : sum17[15:0];
        a_msb   = alu_wide ? opa[15] : opa[7];
        b_msb   = alu_wide ? opb[15] : opb[7];
        r_msb   = alu_wide ? alu_res[15] : alu_res[7];
        f_c     = alu_wide ? sum17[16] : sum17[8];
        f_h     = opa[4] ^ opb[4] ^ alu_res[4];
        f_n     = r_msb;
        f_z     = alu_wide ? (alu_res == 16'h0000) : (alu_res[7:0] == 8'h00);
        f_v     = is_sub ? ((a_msb != b_msb) && (r_msb != a_msb))
                         : ((a_msb == b_msb) && (r_msb != a_msb));
        acc_alu_next = alu_wide ? alu_res : {acc_reg[15:8], alu_res[7:0]};
    end

    // program counter: bus write, then core load, then increment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_reg <= `CRBA_REG_RESET;
        end else if (ce) begin
            if (sw_wr && dph_addr_reg == `CRBA_OFF_PC) begin
                pc_reg <= hwdata[15:0];
            end else if (load_valid && load_sel == crba_pkg::LD_PC) begin
                pc_reg <= load_data;
            end else if (pc_inc) begin
                pc_reg <= pc_reg + 16'h0001;
            end
        end
    end

    // accumulator pair; the alu result lands in the accumulator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_reg <= `CRBA_REG_RESET;
            tmp_reg <= `CRBA_REG_RESET;
        end else if (ce) begin
            if (sw_wr && dph_addr_reg == `CRBA_OFF_ACC) begin
                acc_reg <= hwdata[15:0];
            end else if (load_valid && load_sel == crba_pkg::LD_ACC) begin
                acc_reg <= load_data;
            end else if (alu_valid) begin
                acc_reg <= acc_alu_next;
            end
            if (sw_wr && dph_addr_reg == `CRBA_OFF_TMP) begin
                tmp_reg <= hwdata[15:0];
            end else if (load_valid && load_sel == crba_pkg::LD_TMP) begin
                tmp_reg <= load_data;
            end
        end
    end

    // pointer registers, loaded only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_reg <= `CRBA_REG_RESET;
            ext_reg <= `CRBA_REG_RESET;
            stk_reg <= `CRBA_REG_RESET;
        end else if (ce) begin
            if (sw_wr && dph_addr_reg == `CRBA_OFF_IDX) begin
                idx_reg <= hwdata[15:0];
            end else if (load_valid && load_sel == crba_pkg::LD_IDX) begin
                idx_reg <= load_data;
            end
            if (sw_wr && dph_addr_reg == `CRBA_OFF_EXT) begin
                ext_reg <= hwdata[15:0];
            end else if (load_valid && load_sel == crba_pkg::LD_EXT) begin
                ext_reg <= load_data;
            end
            if (sw_wr && dph_addr_reg == `CRBA_OFF_STK) begin
                stk_reg <= hwdata[15:0];
            end else if (load_valid && load_sel == crba_pkg::LD_STK) begin
                stk_reg <= load_data;
            end
        end
    end

    // program status; a move updates only negative and zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= `CRBA_SR_RESET;
        end else if (ce) begin
            if (sw_wr && dph_addr_reg == `CRBA_OFF_STAT) begin
                status_reg <= hwdata[15:0];
            end else if (load_valid && load_sel == crba_pkg::LD_STAT) begin
                status_reg <= load_data;
            end else if (alu_valid) begin
                status_reg[`CRBA_SR_N] <= f_n;
                status_reg[`CRBA_SR_Z] <= f_z;
                if (alu_op != crba_pkg::ALU_MOVE) begin
                    status_reg[`CRBA_SR_H] <= f_h;
                    status_reg[`CRBA_SR_V] <= f_v;
                    status_reg[`CRBA_SR_C] <= f_c;
                end
            end
        end
    end

    // direct window remap: only the upper half moves, pointer zero is identity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_mapped_reg <= `CRBA_REG_RESET;
            dir_done_reg   <= 1'b0;
        end else if (ce) begin
            dir_done_reg <= dir_valid;
            if (dir_valid) begin
                if (dir_addr[7] && dir_ptr != 3'h0) begin
                    dir_mapped_reg <= `CRBA_DIR_MAP_BASE
                                    + ({13'h0000, dir_ptr_m1} << `CRBA_DIR_WIN_BITS)
                                    + {9'h000, dir_addr[6:0]};
                end else begin
                    dir_mapped_reg <= {8'h00, dir_addr};
                end
            end
        end
    end

    // gp access: address out one edge after the request, data two edges after
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gp_addr_reg  <= `CRBA_REG_RESET;
            gp_pend_reg  <= 1'b0;
            gp_ack_reg   <= 1'b0;
            gp_rdata_reg <= 8'h00;
        end else if (ce) begin
            gp_pend_reg <= gp_valid;
            gp_ack_reg  <= gp_pend_reg;
            if (gp_valid) begin
                gp_addr_reg <= `CRBA_GP_BASE + {8'h00, bank_ptr, gp_opcode[2:0]};
            end
            if (gp_pend_reg) begin
                gp_rdata_reg <= gp_bus.rdata;
            end
        end
    end

    // interrupt gate: enabled and a numerically lower level only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_accept_reg <= 1'b0;
        end else if (ce) begin
            irq_accept_reg <= irq_valid && status_reg[`CRBA_SR_I]
                              && (irq_level < int_level);
        end
    end

    assign hreadyout        = hreadyout_reg;
    assign hresp            = 1'b0;
    assign hrdata           = hrdata_reg;
    assign dir_mapped       = dir_mapped_reg;
    assign dir_done         = dir_done_reg;
    assign gp_addr          = gp_addr_reg;
    assign gp_rdata         = gp_rdata_reg;
    assign gp_ack           = gp_ack_reg;
    assign irq_accept       = irq_accept_reg;
    assign program_counter  = pc_reg;
    assign accumulator      = acc_reg;
    assign temp_accumulator = tmp_reg;
    assign index_register   = idx_reg;
    assign extra_pointer    = ext_reg;
    assign stack_pointer    = stk_reg;
    assign program_status   = status_reg;

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_dir_low_fixed: assert property (ce && dir_valid && !dir_addr[7] |=>
        dir_mapped == {8'h00, $past(dir_addr)}) else $error("low direct address moved");
    a_dir_bank_map: assert property (ce && dir_valid && dir_addr[7] && dir_ptr != 3'h0 |=>
        dir_mapped == 16'h0100 + 16'h0080 * ($past(dir_ptr) - 3'h1) + $past(dir_addr[6:0]))
        else $error("direct window remap wrong");
    a_dir_zero_bank: assert property (ce && dir_valid && dir_ptr == 3'h0 |=>
        dir_mapped[15:8] == 8'h00 && dir_done) else $error("pointer zero remapped");
    a_gp_addr_form: assert property (ce && gp_valid |=>
        gp_addr == 16'h0100 + 8 * $past(bank_ptr) + $past(gp_opcode[2:0]))
        else $error("gp address wrong");
    a_gp_ack_time: assert property (ce && gp_valid ##1 ce |=> gp_ack)
        else $error("gp ack late");
    a_irq_gate: assert property (ce && irq_valid |=> irq_accept ==
        ($past(status_reg[6]) && ($past(irq_level) < $past(int_level))))
        else $error("interrupt gate wrong");
    a_ie_reset: assert property (disable iff (1'b0) $rose(hresetn) |->
        !program_status[6] && !irq_accept) else $error("enable not clear at reset");
    a_half_carry: assert property (ce && alu_valid && !alu_wide && alu_op == 3'h0 && !sw_wr
        && !load_valid |=> program_status[7] ==
        (($past(acc_reg[3:0]) + $past(tmp_reg[3:0])) > 5'h0F)) else $error("half carry wrong");
    a_acc_high_kept: assert property (ce && alu_valid && !alu_wide && !sw_wr && !load_valid |=>
        $stable(accumulator[15:8])) else $error("byte op touched high byte");
    a_pc_step: assert property (ce && pc_inc && !sw_wr && !load_valid |=>
        program_counter == $past(program_counter) + 16'h0001) else $error("pc step wrong");
    a_bus_wait: assert property (!hreadyout |-> ##[1:20] hreadyout)
        else $error("bus wait too long");

    c_half_carry: cover property (ce && alu_valid && f_h);
    c_dir_top: cover property (ce && dir_valid && dir_addr[7] && dir_ptr == 3'h7);
    c_irq_taken: cover property (irq_accept);
    c_bus_gp_read: cover property (state_reg == crba_pkg::ST_RESP && !ahb_gp_we_reg);
endmodule // crba_regbank

/* tb/crba_core_model.sv */
`timescale 1ns/1ps
// decoder-side partner: issues one-cycle request pulses, as the core would
module crba_core_model (
    input  wire logic hclk,
    output logic       pc_inc,
    output logic       load_valid,
    output logic [2:0] load_sel,
    output logic [15:0] load_data,
    output logic       alu_valid,
    output logic [2:0] alu_op,
    output logic       alu_wide,
    output logic       dir_valid,
    output logic [7:0] dir_addr,
    output logic       gp_valid,
    output logic       gp_write,
    output logic [7:0] gp_opcode,
    output logic [7:0] gp_wdata,
    output logic       irq_valid,
    output logic [1:0] irq_level
);
    // idle at time zero so no request lands during reset
    initial begin
        {pc_inc, load_valid, alu_valid, dir_valid, gp_valid, irq_valid} = 6'h00;
        {load_sel, load_data, alu_op, alu_wide, dir_addr} = 31'h0;
        {gp_write, gp_opcode, gp_wdata, irq_level} = 19'h0;
    end
    // k picks the request: 0 pc, 1 load, 2 alu, 3 direct, 4 gp, 5 irq
    // one shared field word keeps the partner small; unused fields are don't-care
    task automatic issue(input logic [2:0] k, input logic [2:0] s, input logic [15:0] d);
        @(posedge hclk);
        {load_sel, alu_op, irq_level, gp_write} <= {s, s, s[1:0], s[0]};
        {load_data, dir_addr, gp_opcode, gp_wdata, alu_wide} <= {d, d[7:0], d[7:0], d[15:8], d[0]};
        {pc_inc, load_valid, alu_valid, dir_valid, gp_valid, irq_valid} <= 6'h20 >> k;
        @(posedge hclk);
        {pc_inc, load_valid, alu_valid, dir_valid, gp_valid, irq_valid} <= 6'h00;
    endtask
endmodule // crba_core_model

/* tb/cpu_register_bank_addressing_tb.sv */
`timescale 1ns/1ps
module cpu_register_bank_addressing_tb;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, pc_inc, load_valid, alu_valid, alu_wide;
    logic        dir_valid, dir_done, gp_valid, gp_write, gp_ack, irq_valid, irq_accept;
    logic [1:0]  htrans, irq_level;
    logic [2:0]  load_sel, alu_op;
    logic [7:0]  dir_addr, gp_opcode, gp_wdata, gp_rdata;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] load_data, dir_mapped, gp_addr, program_counter, accumulator;
    logic [15:0] temp_accumulator, index_register, extra_pointer, stack_pointer, program_status;
    int          mismatches, comparisons;

    crba_regbank dut (.ce(1'b1), .hsel(1'b1), .hsize(3'h2), .hready(hreadyout), .*);
    crba_core_model model (.*);

    // 50 MHz clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // bounded wait for hready high at a rising edge; a hung slave ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        if (hreadyout !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask

    // starts on a rising edge, so every bus change is launched by the clock
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        {htrans, haddr, hwrite} <= {2'h2, a, w};
        wait_ready();
        {htrans, hwdata} <= {2'h0, wd};
        wait_ready();
        rd = hrdata;
    endtask

    task automatic t_bus();
        for (int i = 0; i < 3; i++) begin
            ahb(1'b1, 32'h0C + 4 * i, 32'h5A00 + i);
            ahb(1'b0, 32'h0C + 4 * i, 32'h0);
            chk(rd, 32'h5A00 + i);
        end
        chk(extra_pointer, 16'h5A01);
        chk(index_register, 16'h5A00);
        ahb(1'b1, 32'h1C, 32'hFFFF);
        ahb(1'b0, 32'h1C, 32'h0);
        chk(rd, 32'h0);
        chk(hresp, 1'b0);
    endtask

    task automatic t_pc();
        ahb(1'b1, 32'h00, 32'h1234);
        model.issue(3'h0, 3'h0, 16'h0);
        #1 chk(program_counter, 16'h1235);
        ahb(1'b0, 32'h00, 32'h0);
        chk(rd, 32'h1235);
        // core loads into each pointer, then into the program counter
        for (int s = 3; s < 6; s++) begin
            model.issue(3'h1, 3'(s), 16'h0F00 + 16'(s));
        end
        #1 chk({index_register, extra_pointer}, {16'h0F03, 16'h0F04});
        chk(stack_pointer, 16'h0F05);
        model.issue(3'h1, 3'h0, 16'h8000);
        #1 chk(program_counter, 16'h8000);
    endtask

    // every direct bank value, window and low page
    task automatic t_direct();
        for (int d = 0; d < 8; d++) begin
            model.issue(3'h1, 3'h6, {5'h00, 3'(d), 8'h00});
            model.issue(3'h3, 3'h0, 16'h0085);
            #1 chk(dir_mapped, d == 0 ? 16'h0085 : 16'h0005 + 16'h0080 * (d + 1));
            chk(dir_done, 1'b1);
            model.issue(3'h3, 3'h0, 16'h0010);
            #1 chk(dir_mapped, 16'h0010);
        end
    endtask

    // bank 5, register 3: write from the core, read back from core and bus
    task automatic t_gp();
        model.issue(3'h1, 3'h6, 16'h2800);
        model.issue(3'h4, 3'h1, 16'hA503);
        #1 chk(gp_addr, 16'h012B);
        @(posedge hclk);
        #1 chk(gp_ack, 1'b1);
        model.issue(3'h4, 3'h0, 16'h00FB);
        @(posedge hclk);
        #1 chk(gp_rdata, 8'hA5);
        ahb(1'b0, 32'h4AC, 32'h0);
        chk(rd, 32'hA5);
    endtask

    task automatic t_alu();
        model.issue(3'h1, 3'h1, 16'h120F);
        model.issue(3'h1, 3'h2, 16'h0001);
        model.issue(3'h2, 3'h0, 16'h0000);
        #1 chk(accumulator, 16'h1210);
        chk(program_status[7], 1'b1);
        chk(program_status[0], 1'b0);
        model.issue(3'h2, 3'h0, 16'h0001);
        #1 chk(accumulator, 16'h1211);
        chk(program_status[7], 1'b0);
        chk(temp_accumulator, 16'h0001);
        // move, byte subtracts down through zero, then add with carry
        model.issue(3'h2, 3'h4, 16'h0001);
        #1 chk(accumulator, 16'h0001);
        model.issue(3'h2, 3'h2, 16'h0000);
        #1 chk(program_status[2], 1'b1);
        model.issue(3'h2, 3'h2, 16'h0000);
        #1 chk(accumulator, 16'h00FF);
        chk({program_status[7], program_status[0]}, 2'h3);
        model.issue(3'h2, 3'h1, 16'h0000);
        #1 chk(accumulator, 16'h0001);
    endtask

    task automatic t_irq();
        model.issue(3'h1, 3'h6, 16'h0020);
        model.issue(3'h5, 3'h1, 16'h0);
        #1 chk(irq_accept, 1'b0);
        model.issue(3'h1, 3'h6, 16'h0060);
        model.issue(3'h5, 3'h1, 16'h0);
        #1 chk(irq_accept, 1'b1);
        model.issue(3'h5, 3'h2, 16'h0);
        #1 chk(irq_accept, 1'b0);
    endtask

    // reset held four cycles, then each scenario in turn
    initial begin
        {hresetn, htrans, haddr, hwrite, hwdata, mismatches, comparisons} = '0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        #1 chk(program_status, 16'h0030);
        chk(stack_pointer, 16'h0);
        t_bus();
        t_pc();
        t_direct();
        t_gp();
        t_alu();
        t_irq();
        summarize();
    end
endmodule // cpu_register_bank_addressing_tb
